//--- thermal_defs.svh
`ifndef THERMAL_DEFS_SVH
`define THERMAL_DEFS_SVH
// Read-only and read pointers
`define PTR_RD_LOCAL 8'h00
`define PTR_RD_RWHOLE 8'h01
`define PTR_RD_ALARM 8'h02
`define PTR_RD_CONFIG 8'h03
`define PTR_RD_PACE 8'h04
`define PTR_RD_LUPPER 8'h05
`define PTR_RD_LLOWER 8'h06
`define PTR_RD_RUPPER 8'h07
`define PTR_RD_RLOWER 8'h08
// Write pointers of split registers and of the one-shot trigger
`define PTR_WR_CONFIG 8'h09
`define PTR_WR_PACE 8'h0A
`define PTR_WR_LUPPER 8'h0B
`define PTR_WR_LLOWER 8'h0C
`define PTR_WR_RUPPER 8'h0D
`define PTR_WR_RLOWER 8'h0E
`define PTR_ONE_SHOT 8'h0F
// Same pointer for read and write; remote fraction, maker and die are read-only
`define PTR_RFRAC 8'h10
`define PTR_CORR_WHOLE 8'h11
`define PTR_CORR_FRAC 8'h12
`define PTR_UPPER_FRAC 8'h13
`define PTR_LOWER_FRAC 8'h14
`define PTR_RSHUT 8'h19
`define PTR_LSHUT 8'h20
`define PTR_HYST 8'h21
`define PTR_FILTER 8'hBF
`define PTR_MAKER 8'hFE
`define PTR_DIE 8'hFF
// Reset values
`define RST_CONFIG 8'h00
`define RST_PACE 8'h08
`define RST_UPPER 8'h46
`define RST_ZERO 8'h00
`define RST_SHUT 8'h55
`define RST_HYST 8'h0A
// Field positions and writable masks
`define CFG_ALERT_MASK 7
`define CFG_STANDBY 6
`define CFG_RSHUT_MASK 4
`define CFG_LSHUT_MASK 2
`define CFG_QUEUE 0
`define CFG_WRITABLE 8'hD5
`define FRAC_WRITABLE 8'hE0
`define HYST_WRITABLE 8'h1F
`define FILTER_WRITABLE 8'h07
`define PACE_MAX_CODE 8'h09
`define QUEUE_DEPTH 2'h3
// Timing: slowest conversion period and clock rate
`define PACE_SLOW_MS 16000
`define CLK_KHZ 25000
`endif

//--- thermal_pkg.sv
package thermal_pkg;
   // Serial slave states, one-hot
   typedef enum logic [6:0] {
      SMB_IDLE  = 7'h01,
      SMB_ADDR  = 7'h02,
      SMB_CMD   = 7'h04,
      SMB_WDATA = 7'h08,
      SMB_ACK   = 7'h10,
      SMB_RDATA = 7'h20,
      SMB_RACK  = 7'h40
   } smb_state_e;
   // One result from the converter front end
   typedef struct packed {
      logic [7:0]  local_temp;
      logic [10:0] remote_temp;
      logic        diode_open;
   } conv_result_s;
   // Alarm flag byte, bit 7 first
   typedef struct packed {
      logic busy;
      logic local_above;
      logic local_below;
      logic remote_above;
      logic remote_below;
      logic diode_open;
      logic remote_shut;
      logic local_shut;
   } alarm_flags_s;
endpackage

//--- thermal_monitor_register_map.sv
`timescale 1ns/1ps
`include "thermal_defs.svh"
// Summary of operation
// - Standby one-shot write launches one conversion
// - One-shot stores nothing, reads zero
// - Command byte sets the register pointer
// - Configuration read and write pointers differ
// - Pace code sets conversion frequency
// - Local and remote whole: signed degrees
// - Remote fraction top three bits only
// - Remote reading saturated to 11 bits; local reading passed through unclamped
// - Alarm bit 7 shows converter busy
// - Alarm bits 6..3 and 1..0 hold limit flags
// - Diode open sets alarm bit 2
// - Configuration bit 7 masks alert
// - Configuration bit 6 enters standby
// - Configuration bit 4 masks remote overheat
// - Configuration bit 2 masks local overheat
// - Fault queue needs three remote faults
// - Configuration bits 5,3,1 read zero
// - Pointer resets to zero, then holds
// - Plain read uses latched pointer
module thermal_monitor_register_map
   import thermal_pkg::*;
#(
   parameter logic [6:0]  SLAVE_ADDR       = 7'h4C,
   parameter logic [7:0]  MAKER_ID         = 8'h5A, // Arbitrary value
   parameter logic [7:0]  DIE_REV          = 8'hA5, // Arbitrary value
   parameter int unsigned PACE_SLOW_CYCLES = `PACE_SLOW_MS * `CLK_KHZ
)(
   input  wire logic         CLK_SYS,
   input  wire logic         RESET_N,
   input  wire logic         SMBCLK_IN,
   input  wire logic         SMBDAT_IN,
   output logic              SMBDAT_OUT,
   output logic              SMBDAT_OE,
   output logic              CONV_START,
   input  wire logic         CONV_DONE,
   input  wire conv_result_s CONV_RESULT,
   output logic              ALERT_OE,
   output logic              OVERHEAT_OE,
   output logic [2:0]        FILTER_SETUP
);
   // Pin synchronisers; stage 2 is the previous sample
   logic [2:0]   scl_sync_q;
   logic [2:0]   sda_sync_q;
   // Serial slave state
   smb_state_e   state_q;
   smb_state_e   nxt_q;     // Where to go after the ack bit
   logic [3:0]   cnt_q;     // Bits of the current byte
   logic [7:0]   shift_q;   // Incoming byte
   logic [7:0]   rbyte_q;   // Outgoing byte, shifted out
   logic         acked_q;   // Master ack of a read byte
   logic         oe_q;
   logic         dout_q;
   logic [7:0]   ptr_q;     // Register pointer
   // Registers
   logic [7:0]   cfg_q;
   logic [7:0]   pace_q;
   logic [7:0]   lupper_q;
   logic [7:0]   llower_q;
   logic [7:0]   rupper_q;
   logic [7:0]   rlower_q;
   logic [7:0]   ufrac_q;
   logic [7:0]   lfrac_q;
   logic [7:0]   cwhole_q;
   logic [7:0]   cfrac_q;
   logic [7:0]   rshut_q;
   logic [7:0]   lshut_q;
   logic [7:0]   hyst_q;
   logic [7:0]   filter_q;
   logic [7:0]   local_q;
   logic [7:0]   rwhole_q;
   logic [7:0]   rfrac_q;
   alarm_flags_s flags_q;
   // Conversion control
   logic [31:0]  pace_cnt_q;
   logic         busy_q;
   logic         oneshot_q;
   logic         start_q;
   logic [1:0]   queue_q [3];  // Remote above, below, shut

   // Two flops before any logic looks at the pins
   always_ff @(posedge CLK_SYS or negedge RESET_N)
      if (!RESET_N)
      begin
         scl_sync_q <= 3'h7;
         sda_sync_q <= 3'h7;
      end
      else
      begin
         scl_sync_q <= {scl_sync_q[1:0], SMBCLK_IN};
         sda_sync_q <= {sda_sync_q[1:0], SMBDAT_IN};
      end

   // Bus events
   wire scl      = scl_sync_q[1];
   wire sda      = sda_sync_q[1];
   wire scl_rise = scl & ~scl_sync_q[2];
   wire scl_fall = ~scl & scl_sync_q[2];
   wire start_ev = scl & scl_sync_q[2] & sda_sync_q[2] & ~sda;
   wire stop_ev  = scl & scl_sync_q[2] & ~sda_sync_q[2] & sda;
   wire byte_in  = (state_q == SMB_ADDR) | (state_q == SMB_CMD) | (state_q == SMB_WDATA);
   wire byte_end = scl_fall & (cnt_q == 4'h8);
   wire addr_hit = (shift_q[7:1] == SLAVE_ADDR);
   wire cmd_fire = byte_end & (state_q == SMB_CMD);
   wire wr_fire  = byte_end & (state_q == SMB_WDATA);

   // Read selection; unknown and write-only pointers give zero
   wire [7:0] rd_mux =
      (ptr_q == `PTR_RD_LOCAL)   ? local_q  :
      (ptr_q == `PTR_RD_RWHOLE)  ? rwhole_q :
      (ptr_q == `PTR_RD_ALARM)   ? flags_q  :
      (ptr_q == `PTR_RD_CONFIG)  ? cfg_q    :
      (ptr_q == `PTR_RD_PACE)    ? pace_q   :
      (ptr_q == `PTR_RD_LUPPER)  ? lupper_q :
      (ptr_q == `PTR_RD_LLOWER)  ? llower_q :
      (ptr_q == `PTR_RD_RUPPER)  ? rupper_q :
      (ptr_q == `PTR_RD_RLOWER)  ? rlower_q :
      (ptr_q == `PTR_RFRAC)      ? rfrac_q  :
      (ptr_q == `PTR_CORR_WHOLE) ? cwhole_q :
      (ptr_q == `PTR_CORR_FRAC)  ? cfrac_q  :
      (ptr_q == `PTR_UPPER_FRAC) ? ufrac_q  :
      (ptr_q == `PTR_LOWER_FRAC) ? lfrac_q  :
      (ptr_q == `PTR_RSHUT)      ? rshut_q  :
      (ptr_q == `PTR_LSHUT)      ? lshut_q  :
      (ptr_q == `PTR_HYST)       ? hyst_q   :
      (ptr_q == `PTR_FILTER)     ? filter_q :
      (ptr_q == `PTR_MAKER)      ? MAKER_ID :
      (ptr_q == `PTR_DIE)        ? DIE_REV  : `RST_ZERO;

   // Serial slave; start and stop override any state
   always_ff @(posedge CLK_SYS or negedge RESET_N)
      if (!RESET_N)
      begin
         state_q <= SMB_IDLE;
         nxt_q   <= SMB_IDLE;
         cnt_q   <= 4'h0;
         shift_q <= 8'h00;
         rbyte_q <= 8'h00;
         acked_q <= 1'b0;
         oe_q    <= 1'b0;
         dout_q  <= 1'b0;
         ptr_q   <= `RST_ZERO;
      end
      else if (start_ev)
      begin
         state_q <= SMB_ADDR;
         cnt_q   <= 4'h0;
         oe_q    <= 1'b0;
      end
      else if (stop_ev)
      begin
         state_q <= SMB_IDLE;
         oe_q    <= 1'b0;
      end
      else
      begin
         // Sample on rising clock
         if (scl_rise && byte_in)
         begin
            shift_q <= {shift_q[6:0], sda};
            cnt_q   <= cnt_q + 4'h1;
         end
         if (scl_rise && state_q == SMB_RDATA)
            cnt_q <= cnt_q + 4'h1;
         if (scl_rise && state_q == SMB_RACK)
            acked_q <= ~sda;
         // Drive on falling clock
         if (scl_fall)
            case (state_q)
               SMB_ADDR:
                  if (cnt_q == 4'h8)
                  begin
                     // Other addresses are not ours; wait for next start
                     state_q <= addr_hit ? SMB_ACK : SMB_IDLE;
                     oe_q    <= addr_hit;
                     nxt_q   <= shift_q[0] ? SMB_RDATA : SMB_CMD;
                     rbyte_q <= rd_mux;
                  end
               SMB_CMD:
                  if (cnt_q == 4'h8)
                  begin
                     ptr_q   <= shift_q;
                     state_q <= SMB_ACK;
                     oe_q    <= 1'b1;
                     nxt_q   <= SMB_WDATA;
                  end
               SMB_WDATA:
                  if (cnt_q == 4'h8)
                  begin
                     // Only one data byte per write
                     state_q <= SMB_ACK;
                     oe_q    <= 1'b1;
                     nxt_q   <= SMB_IDLE;
                  end
               SMB_ACK:
               begin
                  state_q <= nxt_q;
                  cnt_q   <= 4'h0;
                  oe_q    <= (nxt_q == SMB_RDATA) & ~rbyte_q[7];
                  rbyte_q <= {rbyte_q[6:0], 1'b0};
               end
               SMB_RDATA:
                  if (cnt_q == 4'h8)
                  begin
                     state_q <= SMB_RACK;
                     oe_q    <= 1'b0;
                  end
                  else
                  begin
                     oe_q    <= ~rbyte_q[7];
                     rbyte_q <= {rbyte_q[6:0], 1'b0};
                  end
               SMB_RACK:
               begin
                  // Ack asks for the same register again; nack ends
                  state_q <= acked_q ? SMB_RDATA : SMB_IDLE;
                  cnt_q   <= 4'h0;
                  oe_q    <= acked_q & ~rd_mux[7];
                  rbyte_q <= {rd_mux[6:0], 1'b0};
               end
               default:
                  oe_q <= 1'b0;
            endcase
      end

   // Write decode, strobes for configuration, pace and one-shot only
   wire wr_cfg    = wr_fire & (ptr_q == `PTR_WR_CONFIG);
   wire wr_pace   = wr_fire & (ptr_q == `PTR_WR_PACE);
   wire wr_oneshot = wr_fire & (ptr_q == `PTR_ONE_SHOT);
   wire standby   = cfg_q[`CFG_STANDBY];

   // Register writes; read-only and unknown pointers fall through
   always_ff @(posedge CLK_SYS or negedge RESET_N)
      if (!RESET_N)
      begin
         cfg_q    <= `RST_CONFIG;
         pace_q   <= `RST_PACE;
         lupper_q <= `RST_UPPER;
         llower_q <= `RST_ZERO;
         rupper_q <= `RST_UPPER;
         rlower_q <= `RST_ZERO;
         ufrac_q  <= `RST_ZERO;
         lfrac_q  <= `RST_ZERO;
         cwhole_q <= `RST_ZERO;
         cfrac_q  <= `RST_ZERO;
         rshut_q  <= `RST_SHUT;
         lshut_q  <= `RST_SHUT;
         hyst_q   <= `RST_HYST;
         filter_q <= `RST_ZERO;
      end
      else if (wr_fire)
         case (ptr_q)
            `PTR_WR_CONFIG:  cfg_q    <= shift_q & `CFG_WRITABLE;
            `PTR_WR_PACE:    pace_q   <= shift_q;
            `PTR_WR_LUPPER:  lupper_q <= shift_q;
            `PTR_WR_LLOWER:  llower_q <= shift_q;
            `PTR_WR_RUPPER:  rupper_q <= shift_q;
            `PTR_WR_RLOWER:  rlower_q <= shift_q;
            `PTR_UPPER_FRAC: ufrac_q  <= shift_q & `FRAC_WRITABLE;
            `PTR_LOWER_FRAC: lfrac_q  <= shift_q & `FRAC_WRITABLE;
            `PTR_CORR_WHOLE: cwhole_q <= shift_q;
            `PTR_CORR_FRAC:  cfrac_q  <= shift_q & `FRAC_WRITABLE;
            `PTR_RSHUT:      rshut_q  <= shift_q;
            `PTR_LSHUT:      lshut_q  <= shift_q;
            `PTR_HYST:       hyst_q   <= shift_q & `HYST_WRITABLE;
            `PTR_FILTER:     filter_q <= shift_q & `FILTER_WRITABLE;
            default:         cfg_q    <= cfg_q;
         endcase

   // Pace timer; codes above the top are held at the top rate
   wire [3:0]  pace_code = (pace_q > `PACE_MAX_CODE) ? 4'h9 : pace_q[3:0];
   wire [31:0] pace_period = PACE_SLOW_CYCLES >> pace_code;
   wire        pace_hit = (pace_cnt_q + 32'h1 >= pace_period);
   wire        launch = ~busy_q & ~start_q & (oneshot_q | (pace_hit & ~standby));

   // Launch control; a new one-shot write beats its own clear
   always_ff @(posedge CLK_SYS or negedge RESET_N)
      if (!RESET_N)
      begin
         pace_cnt_q <= 32'h0;
         busy_q     <= 1'b0;
         oneshot_q  <= 1'b0;
         start_q    <= 1'b0;
      end
      else
      begin
         pace_cnt_q <= (standby | launch) ? 32'h0 : (pace_hit ? pace_cnt_q : pace_cnt_q + 32'h1);
         oneshot_q  <= (wr_oneshot & standby) | (oneshot_q & ~launch);
         start_q    <= launch;
         busy_q     <= launch | (busy_q & ~CONV_DONE);
      end

   // Remote value with correction, saturated to 11 bits
   wire [11:0] rsum = {CONV_RESULT.remote_temp[10], CONV_RESULT.remote_temp}
                    + {cwhole_q[7], cwhole_q, cfrac_q[7:5]};
   wire [10:0] rclamp = (rsum[11] == rsum[10]) ? rsum[10:0]
                      : (rsum[11] ? 11'h400 : 11'h3FF);
   wire        open_d = CONV_RESULT.diode_open;
   wire [10:0] rval = open_d ? {8'h7F, 3'h0} : rclamp;
   wire [7:0]  lval = CONV_RESULT.local_temp;
   wire        done = CONV_DONE & busy_q;

   // Limit comparisons; shutdown flags clear below limit minus hysteresis
   wire [8:0]  lkeep = {lshut_q[7], lshut_q} - {1'b0, hyst_q};
   wire [8:0]  rkeep = {rshut_q[7], rshut_q} - {1'b0, hyst_q};
   wire        l_above = $signed(lval) > $signed(lupper_q);
   wire        l_below = $signed(lval) < $signed(llower_q);
   wire        l_shut = flags_q.local_shut ? ($signed({lval[7], lval}) > $signed(lkeep))
                                           : ($signed(lval) > $signed(lshut_q));
   wire        r_above = $signed(rval) > $signed({rupper_q, ufrac_q[7:5]});
   wire        r_below = $signed(rval) < $signed({rlower_q, lfrac_q[7:5]});
   wire        r_shut = flags_q.remote_shut ? ($signed({rval[10], rval}) > $signed({rkeep, 3'h0}))
                                            : ($signed(rval) > $signed({rshut_q, 3'h0}));
   wire [2:0]  r_fault = {r_shut, r_below, r_above};
   wire [1:0]  need = cfg_q[`CFG_QUEUE] ? `QUEUE_DEPTH : 2'h1;
   logic [2:0] r_pass;
   logic [1:0] queue_d [3];

   // Consecutive remote faults, saturating at the queue depth
   always_comb
      for (int i = 0; i < 3; i++)
      begin
         queue_d[i] = r_fault[i] ? ((queue_q[i] == `QUEUE_DEPTH) ? queue_q[i]
                                    : queue_q[i] + 2'h1) : 2'h0;
         r_pass[i] = (queue_d[i] >= need);
      end

   // Readings and limit flags refresh at the end of each conversion; busy every cycle
   always_ff @(posedge CLK_SYS or negedge RESET_N)
      if (!RESET_N)
      begin
         local_q  <= `RST_ZERO;
         rwhole_q <= `RST_ZERO;
         rfrac_q  <= `RST_ZERO;
         flags_q  <= '0;
         for (int i = 0; i < 3; i++)
            queue_q[i] <= 2'h0;
      end
      else
      begin
         flags_q.busy <= launch | (busy_q & ~CONV_DONE);
         if (done)
         begin
            local_q  <= lval;
            rwhole_q <= rval[10:3];
            rfrac_q  <= {rval[2:0], 5'h00};
            queue_q  <= queue_d;
            flags_q.local_above  <= l_above;
            flags_q.local_below  <= l_below;
            flags_q.remote_above <= r_pass[0];
            flags_q.remote_below <= r_pass[1];
            flags_q.diode_open   <= open_d;
            flags_q.remote_shut  <= r_pass[2];
            flags_q.local_shut   <= l_shut;
         end
      end

   // Open-drain pins, pulled low while the enable is high
   always_ff @(posedge CLK_SYS or negedge RESET_N)
      if (!RESET_N)
      begin
         ALERT_OE    <= 1'b0;
         OVERHEAT_OE <= 1'b0;
      end
      else
      begin
         // Diode open alone never alerts
         ALERT_OE <= ~cfg_q[`CFG_ALERT_MASK] & (|{flags_q[6:3], flags_q[1:0]});
         OVERHEAT_OE <= (flags_q.local_shut & ~cfg_q[`CFG_LSHUT_MASK])
                      | (flags_q.remote_shut & ~flags_q.diode_open
                         & ~cfg_q[`CFG_RSHUT_MASK]);
      end

   assign SMBDAT_OUT   = dout_q;
   assign SMBDAT_OE    = oe_q;
   assign CONV_START   = start_q;
   assign FILTER_SETUP = filter_q[2:0];

   // Checks
   default clocking @(posedge CLK_SYS); endclocking
   default disable iff (!RESET_N);

   a_oneshot_launch: assert property (
      wr_oneshot && standby && !busy_q && !start_q && !oneshot_q
         |=> ##1 CONV_START ##1 !CONV_START)
      else $error("One-shot did not launch one conversion");
   a_standby_quiet: assert property (
      standby && !oneshot_q && !$past(wr_oneshot) |=> !CONV_START)
      else $error("Conversion launched in standby");
   a_ptr_changes: assert property ($changed(ptr_q) |-> $past(cmd_fire))
      else $error("Pointer changed without command byte");
   a_cfg_zero_bits: assert property ((cfg_q & ~`CFG_WRITABLE) == 8'h00)
      else $error("Unused configuration bits set");
   a_frac_low_zero: assert property (rfrac_q[4:0] == 5'h00)
      else $error("Remote fraction low bits set");
   a_busy_bit: assert property (CONV_START |=> flags_q.busy [*1] ##0 busy_q)
      else $error("Busy flag missing after launch");
   a_alert_masked: assert property ($past(cfg_q[7]) |-> !ALERT_OE)
      else $error("Alert driven while masked");
   a_shut_masked: assert property ($past(cfg_q[4] & cfg_q[2]) |-> !OVERHEAT_OE)
      else $error("Overheat driven while masked");
   a_oneshot_zero: assert property (ptr_q == `PTR_ONE_SHOT |-> rd_mux == 8'h00)
      else $error("One-shot pointer reads nonzero");
   a_open_flag: assert property (done && open_d |=> flags_q.diode_open && rwhole_q == 8'h7F)
      else $error("Diode open not reported");

   c_oneshot: cover property (wr_oneshot && standby ##[1:4] CONV_START);
   c_read_byte: cover property (state_q == SMB_RDATA ##[1:400] state_q == SMB_RACK);
   c_write_byte: cover property (wr_fire && ptr_q == `PTR_WR_CONFIG);
   c_queue_full: cover property (done && cfg_q[0] && r_pass[0]);
endmodule

//--- smb_host_model.sv
`timescale 1ns/1ps
// Bus master: bit-banged clock, open-drain data with a pull-up
module smb_host_model (
   input  wire logic CLK_SYS,
   input  wire logic SMBDAT_OE,
   output logic      SMBCLK,
   output logic      SMBDAT
);
   logic       drv = 1'b1; // Master data drive, 1 = released
   logic [6:0] dev = 7'h4C; // Target address
   logic       rx; // Last sampled data bit
   // Pull-up wins unless a party pulls low
   assign SMBDAT = drv & ~SMBDAT_OE;
   // Clock idles high and stands still between frames
   initial SMBCLK = 1'b1;
   // Quarter bit: two system clocks, so a bit lasts 320 ns
   task automatic q();
      repeat (2) @(posedge CLK_SYS);
      #1;
   endtask
   // Start, also used as repeated start
   task automatic sta();
      drv = 1'b1;
      q();
      // Extra quarter lets the slave drop its ack before the clock rises
      q();
      SMBCLK = 1'b1;
      q();
      drv = 1'b0;
      q();
      SMBCLK = 1'b0;
   endtask
   // Data changes mid-low, sampled mid-high
   task automatic bit1(input logic b);
      q();
      drv = b;
      q();
      SMBCLK = 1'b1;
      q();
      rx = SMBDAT;
      q();
      SMBCLK = 1'b0;
   endtask
   task automatic sto();
      q();
      drv = 1'b0;
      q();
      SMBCLK = 1'b1;
      q();
      drv = 1'b1;
      q();
   endtask
   // Byte out MSB first, ack folded into ok
   task automatic bout(input logic [7:0] v, inout logic ok);
      for (int i = 7; i >= 0; i--) bit1(v[i]);
      bit1(1'b1);
      ok = ok & ~rx;
   endtask
   // Address, pointer, exactly one data byte
   task automatic wr(input logic [7:0] p, input logic [7:0] v, output logic ok);
      ok = 1'b1;
      sta();
      bout({dev, 1'b0}, ok);
      bout(p, ok);
      bout(v, ok);
      sto();
   endtask
   // Plain read of one byte, master ends with no-ack
   task automatic rdp(output logic [7:0] v, inout logic ok);
      sta();
      bout({dev, 1'b1}, ok);
      for (int i = 7; i >= 0; i--)
      begin
         bit1(1'b1);
         v[i] = rx;
      end
      bit1(1'b1);
      sto();
   endtask
   // Pointer set, then repeated start and read
   task automatic rd(input logic [7:0] p, output logic [7:0] v, output logic ok);
      ok = 1'b1;
      sta();
      bout({dev, 1'b0}, ok);
      bout(p, ok);
      rdp(v, ok);
   endtask
endmodule

//--- thermal_monitor_register_map_tb.sv
`timescale 1ns/1ps
// Bench: host model on the bus, behavioural front end on the converter port
module thermal_monitor_register_map_tb import thermal_pkg::*;;
   localparam logic [7:0] MAKER = 8'h3C; // Arbitrary value
   localparam logic [7:0] DIE = 8'hC3; // Arbitrary value
   // Pointer and expected byte, power-up values
   localparam logic [15:0] DEFS [12] = '{16'h0300, 16'h0408, 16'h0546, 16'h0600,
      16'h0746, 16'h0800, 16'h1955, 16'h2055, 16'h210A, 16'h0F00, 16'hFFC3, 16'hFE3C};
   logic         clk = 1'b0;
   logic         rst_n = 1'b0;
   logic         scl, sda, oe, start, alert, oh, ok, dout;
   logic [2:0]   flt; // Filter setup pin
   logic         done = 1'b0; // Front end completion pulse
   logic [7:0]   d; // Last byte read
   conv_result_s res = '{8'h19, 11'h000, 1'b0}; // Result the front end hands back
   int           err_count = 0, checks = 0, starts = 0, dly = 2, cnt = 0;
   always #20 clk = ~clk;
   // Front end: answers each launch dly cycles later
   always @(posedge clk)
   begin
      if (start) cnt <= dly;
      else if (cnt != 0) cnt <= cnt - 1;
      done <= (cnt == 1) && !start;
      starts <= starts + int'(start);
   end
   // Faster pace base; front end latency stays small beside the period
   thermal_monitor_register_map #(.MAKER_ID(MAKER), .DIE_REV(DIE), .PACE_SLOW_CYCLES(25600))
      i_thermal_monitor_register_map (.CLK_SYS(clk), .RESET_N(rst_n), .SMBCLK_IN(scl),
      .SMBDAT_IN(sda), .SMBDAT_OUT(dout), .SMBDAT_OE(oe), .CONV_START(start), .CONV_DONE(done),
      .CONV_RESULT(res), .ALERT_OE(alert), .OVERHEAT_OE(oh), .FILTER_SETUP(flt));
   smb_host_model i_smb_host_model (.CLK_SYS(clk), .SMBDAT_OE(oe), .SMBCLK(scl), .SMBDAT(sda));
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      checks++;
      if (g !== e)
      begin
         err_count++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic complete_run();
      if (err_count == 0 && checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // Register write, ack must come back
   task automatic w(input logic [7:0] p, input logic [7:0] v);
      i_smb_host_model.wr(p, v, ok);
      chk("write ack", 8'h01, {7'h00, ok});
   endtask
   task automatic r(input logic [7:0] p, input logic [7:0] e);
      i_smb_host_model.rd(p, d, ok);
      chk("read ack", 8'h01, {7'h00, ok});
      chk($sformatf("reg %h", p), e, d);
   endtask
   // Bounded wait for a launch count, then let flags and pins settle
   task automatic wait_starts(input int n);
      for (int i = 0; i < 3000 && starts < n; i++) @(posedge clk);
      if (starts < n)
      begin
         err_count++;
         complete_run();
      end
      repeat (dly + 4) @(posedge clk);
      #1;
   endtask
   // Pointer zero after reset, defaults, pointer holds after a read
   task automatic t_defaults();
      wait_starts(1);
      ok = 1'b1;
      i_smb_host_model.rdp(d, ok);
      chk("plain read", 8'h19, d);
      foreach (DEFS[i]) r(DEFS[i][15:8], DEFS[i][7:0]);
      i_smb_host_model.rdp(d, ok);
      chk("plain read", MAKER, d);
   endtask
   // Split addresses, dead bits, ignored writes
   task automatic t_config();
      w(8'h09, 8'hFF);
      w(8'h03, 8'h00);
      w(8'h04, 8'h00);
      w(8'hB5, 8'h77);
      r(8'h03, 8'hD5);
      r(8'h04, 8'h08);
      r(8'hB5, 8'h00);
      w(8'hBF, 8'hFF);
      r(8'hBF, 8'h07);
      chk("filter pin", 8'h07, {5'h00, flt});
      chk("data drive", 8'h00, {7'h00, dout});
      w(8'h09, 8'h40);
   endtask
   // Foreign address gets no ack and stores nothing
   task automatic t_noack();
      i_smb_host_model.dev = 7'h4D;
      i_smb_host_model.wr(8'h09, 8'hC0, ok);
      i_smb_host_model.dev = 7'h4C;
      chk("no ack", 8'h00, {7'h00, ok});
      r(8'h03, 8'h40);
   endtask
   // Standby: no launches until a trigger write, then exactly one
   task automatic t_oneshot();
      int s;
      dly = 400;
      s = starts;
      repeat (400) @(posedge clk);
      chk("idle launches", 8'h00, 8'(starts - s));
      w(8'h0F, 8'hAA);
      r(8'h02, 8'h80);
      wait_starts(s + 1);
      r(8'h02, 8'h00);
      chk("launches", 8'h01, 8'(starts - s));
      dly = 2;
   endtask
   // One triggered conversion, then readings, flags and pins
   task automatic t_case(input logic [7:0] c, k, l, input logic [10:0] rm, input logic op,
      input logic [10:0] er, input logic [7:0] f, input logic al, ov);
      int s;
      s = starts;
      w(8'h09, c);
      w(8'h11, k);
      res = '{l, rm, op};
      w(8'h0F, 8'h00);
      wait_starts(s + 1);
      r(8'h00, l);
      r(8'h01, er[10:3]);
      r(8'h10, {er[2:0], 5'h00});
      r(8'h02, f);
      chk("alert pin", {7'h00, al}, {7'h00, alert});
      chk("overheat pin", {7'h00, ov}, {7'h00, oh});
   endtask
   // Launch count over a window for codes 9, 8 and 7
   task automatic t_pace();
      int s, e;
      w(8'h09, 8'h00);
      for (int c = 9; c >= 7; c--)
      begin
         w(8'h0A, 8'(c));
         s = starts;
         e = (4000 << c) / 25600;
         repeat (4000) @(posedge clk);
         chk("pace", 8'h01, {7'h00, (starts - s) inside {[e * 15 / 16 - 1:e + 1]}});
      end
      r(8'h04, 8'h07);
   endtask
   initial
   begin
      repeat (20) @(posedge clk);
      #1;
      rst_n = 1'b1;
      repeat (4) @(posedge clk);
      t_defaults();
      t_config();
      t_noack();
      t_oneshot();
      t_case(8'h40, 8'h00, 8'h50, 11'h325, 1'b0, 11'h325, 8'h52, 1'b1, 1'b1);
      t_case(8'h50, 8'h00, 8'h50, 11'h325, 1'b0, 11'h325, 8'h52, 1'b1, 1'b0);
      t_case(8'hC0, 8'h00, 8'h50, 11'h325, 1'b0, 11'h325, 8'h52, 1'b0, 1'b1);
      t_case(8'h44, 8'h00, 8'h60, 11'h100, 1'b0, 11'h100, 8'h41, 1'b1, 1'b0);
      t_case(8'h41, 8'h00, 8'h19, 11'h325, 1'b0, 11'h325, 8'h00, 1'b0, 1'b0);
      t_case(8'h41, 8'h00, 8'h19, 11'h325, 1'b0, 11'h325, 8'h00, 1'b0, 1'b0);
      t_case(8'h41, 8'h00, 8'h19, 11'h325, 1'b0, 11'h325, 8'h12, 1'b1, 1'b1);
      t_case(8'h40, 8'h00, 8'h19, 11'h000, 1'b1, 11'h3F8, 8'h16, 1'b1, 1'b0);
      t_case(8'h40, 8'h05, 8'h19, 11'h3FF, 1'b0, 11'h3FF, 8'h12, 1'b1, 1'b1);
      t_pace();
      complete_run();
   end
   // Hang guard
   initial
   begin
      #4000000;
      err_count++;
      complete_run();
   end
endmodule
